// >>> ssp_top.sv
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module ssp_top (
  input  wire logic                       I_CORE_CLK,
  input  wire logic                       I_NRST,
  input  wire logic                       PSEL,
  input  wire logic                       PENABLE,
  input  wire logic                       PWRITE,
  input  wire logic [ssp_pkg::ADDR_W-1:0] PADDR,
  input  wire logic [ssp_pkg::DATA_W-1:0] PWDATA,
  output logic      [ssp_pkg::DATA_W-1:0] PRDATA,
  output logic                            PREADY,
  output logic                            PSLVERR,
  input  wire logic                       I_SHIFT_CLK_PIN,
  output logic                            O_SHIFT_CLK_PIN,
  output logic                            O_SHIFT_CLK_PIN_OE,
  input  wire logic                       I_SERIAL_IN,
  output logic                            O_SERIAL_OUT_PIN,
  output logic                            O_SERIAL_OUT_PIN_OE,
  output logic                            O_FLOW_REQUEST_OUT,
  output logic                            O_FLOW_REQUEST_OUT_OE,
  input  wire logic                       I_CLEAR_TO_SEND_IN,
  input  wire logic                       I_FORCED_CUTOFF_IN_N,
  output logic                            O_SIMPLE_SERIAL_OUT,
  output logic                            O_SIMPLE_SERIAL_OUT_OE
);

  ssp_pkg::ssp_ctrl0_t          ctrl0;
  ssp_pkg::ssp_spec_t           spec;
  ssp_pkg::ssp_state_t          state;
  logic                         tx_enable_bit;
  logic                         rx_enable_bit;
  logic                         tx_buf_empty_flag;
  logic                         rx_full;
  logic                         overrun;
  logic                         rx_pending_flag;
  logic                         tx_pending_flag;
  logic [ssp_pkg::WORD_W-1:0]   tx_buffer;
  logic [ssp_pkg::WORD_W-1:0]   rx_buffer;
  logic [ssp_pkg::WORD_W-1:0]   shreg;
  logic [ssp_pkg::CNT_W-1:0]    bit_cnt;
  logic [ssp_pkg::CNT_W-1:0]    div_cnt;
  logic [ssp_pkg::CNT_W-1:0]    dflt_cnt;
  logic                         int_clk;
  logic                         clk_prev;
  logic                         sim_cond_prev;
  logic                         pf_prev;
  logic [3:0]                   pins_sync;
  logic                         ext_clk;
  logic                         ser_in;
  logic                         cts_in;
  logic                         cutoff_in_n;
  logic                         clk_now;
  logic                         idle_level;
  logic                         rise;
  logic                         fall;
  logic                         launch;
  logic                         capture;
  logic                         start;
  logic                         done;
  logic                         cut;
  logic                         sim_cond;
  logic [ssp_pkg::WORD_W-1:0]   rx_word;
  logic                         setup;
  logic                         access;
  logic                         wr;
  logic                         rd;
  logic                         mapped;
  logic [ssp_pkg::DATA_W-1:0]   next_prdata;

  // Every pin from the far side is retimed before any logic looks at it.
  ssp_sync2 #(
    .W (4)
  ) u_sync (
    .i_clk  (I_CORE_CLK),
    .i_nrst (I_NRST),
    .i_d    ({I_SHIFT_CLK_PIN, I_SERIAL_IN, I_CLEAR_TO_SEND_IN, I_FORCED_CUTOFF_IN_N}),
    .o_q    (pins_sync)
  );

  assign ext_clk     = pins_sync[3];
  assign ser_in      = pins_sync[2];
  assign cts_in      = pins_sync[1];
  assign cutoff_in_n = pins_sync[0];

  // APB slave: zero wait states, read data captured in the setup cycle.
  assign setup   = PSEL && !PENABLE;
  assign access  = PSEL && PENABLE;
  assign mapped  = (PADDR == ssp_pkg::OFF_CTRL0) || (PADDR == ssp_pkg::OFF_CTRL1) ||
                   (PADDR == ssp_pkg::OFF_TXBUF) || (PADDR == ssp_pkg::OFF_RXBUF) ||
                   (PADDR == ssp_pkg::OFF_PEND)  || (PADDR == ssp_pkg::OFF_SPEC);
  assign wr      = access && PWRITE && mapped;
  assign rd      = access && !PWRITE && mapped;
  assign PREADY  = 1'b1;
  assign PSLVERR = access && !mapped;

  always_comb begin
    next_prdata = '0;
    case (PADDR)
      ssp_pkg::OFF_CTRL0: next_prdata = ssp_pkg::DATA_W'(ctrl0);
      ssp_pkg::OFF_CTRL1: begin
        next_prdata[ssp_pkg::TXEN_BIT]    = tx_enable_bit;
        next_prdata[ssp_pkg::RXEN_BIT]    = rx_enable_bit;
        next_prdata[ssp_pkg::TXEMPTY_BIT] = tx_buf_empty_flag;
        next_prdata[ssp_pkg::RXFULL_BIT]  = rx_full;
        next_prdata[ssp_pkg::OVR_BIT]     = overrun;
      end
      ssp_pkg::OFF_TXBUF: next_prdata = ssp_pkg::DATA_W'(tx_buffer);
      ssp_pkg::OFF_RXBUF: next_prdata = ssp_pkg::DATA_W'(rx_buffer);
      ssp_pkg::OFF_PEND: begin
        next_prdata[ssp_pkg::PEND_RX_BIT] = rx_pending_flag;
        next_prdata[ssp_pkg::PEND_TX_BIT] = tx_pending_flag;
      end
      ssp_pkg::OFF_SPEC:  next_prdata = ssp_pkg::DATA_W'(spec);
      default:            next_prdata = '0;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      PRDATA <= '0;
    end else if (setup) begin
      PRDATA <= next_prdata;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl0         <= ssp_pkg::CTRL0_RST;
      spec          <= ssp_pkg::SPEC_RST;
      tx_enable_bit <= 1'b0;
      rx_enable_bit <= 1'b0;
    end else if (wr) begin
      if (PADDR == ssp_pkg::OFF_CTRL0) begin
        ctrl0 <= PWDATA[ssp_pkg::CTRL0_W-1:0];
      end
      if (PADDR == ssp_pkg::OFF_SPEC) begin
        spec <= PWDATA[ssp_pkg::SPEC_W-1:0];
      end
      if (PADDR == ssp_pkg::OFF_CTRL1) begin
        tx_enable_bit <= PWDATA[ssp_pkg::TXEN_BIT];
        rx_enable_bit <= PWDATA[ssp_pkg::RXEN_BIT];
      end
    end
  end

  // Shift clock edges; the internal clock goes through the same detector so
  // both sources launch and sample with identical timing.
  assign clk_now    = ctrl0.internal_clk ? int_clk : ext_clk;
  assign idle_level = !ctrl0.clock_edge_select;
  assign rise       = clk_now && !clk_prev;
  assign fall       = !clk_now && clk_prev;
  assign launch     = ctrl0.clock_edge_select ? rise : fall;
  assign capture    = ctrl0.clock_edge_select ? fall : rise;

  // A transfer only begins with the clock resting at idle, so a peer that
  // leaves it mid-level cannot make the first sampled edge a stray one.
  assign start = (state == ssp_pkg::ST_IDLE) && tx_enable_bit && !tx_buf_empty_flag &&
                 (!ctrl0.cts_enable || !cts_in) &&
                 (clk_now == idle_level);
  assign done  = (state == ssp_pkg::ST_SHIFT) && capture && (bit_cnt == ssp_pkg::LAST_BIT);
  assign rx_word = {ser_in, shreg[ssp_pkg::WORD_W-1:1]};

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      clk_prev <= 1'b1;
    end else begin
      clk_prev <= clk_now;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state   <= ssp_pkg::ST_IDLE;
      shreg   <= '0;
      bit_cnt <= '0;
    end else begin
      case (state)
        ssp_pkg::ST_IDLE: begin
          if (start) begin
            // The buffered word, dummy or real, becomes the outgoing data.
            shreg   <= tx_buffer;
            bit_cnt <= '0;
            state   <= ssp_pkg::ST_SHIFT;
          end
        end
        ssp_pkg::ST_SHIFT: begin
          if (capture) begin
            shreg   <= rx_word;
            bit_cnt <= bit_cnt + 1'b1;
            if (done) begin
              state <= ssp_pkg::ST_IDLE;
            end
          end
        end
        default: state <= ssp_pkg::ST_IDLE;
      endcase
    end
  end

  // Internal clock generator, runs only while a word is in flight.
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      int_clk <= 1'b1;
      div_cnt <= '0;
    end else if (!ctrl0.internal_clk || state == ssp_pkg::ST_IDLE) begin
      int_clk <= idle_level;
      div_cnt <= '0;
    end else if (div_cnt == ssp_pkg::HALF_DIV - 1'b1) begin
      int_clk <= !int_clk;
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_SERIAL_OUT_PIN <= 1'b1;
    end else if (state == ssp_pkg::ST_SHIFT && launch) begin
      O_SERIAL_OUT_PIN <= shreg[0];
    end
  end

  // Transmit buffer; a write in the same cycle as the load wins, so data
  // written then is kept for the next word rather than lost.
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      tx_buffer         <= ssp_pkg::TXBUF_RST;
      tx_buf_empty_flag <= 1'b1;
    end else if (wr && PADDR == ssp_pkg::OFF_TXBUF) begin
      tx_buffer         <= PWDATA[ssp_pkg::WORD_W-1:0];
      tx_buf_empty_flag <= 1'b0;
    end else if (start) begin
      tx_buf_empty_flag <= 1'b1;
    end
  end

  // Receive side; an incoming word beats a simultaneous read of the buffer.
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rx_buffer <= '0;
      rx_full   <= 1'b0;
      overrun   <= 1'b0;
    end else begin
      if (done && rx_enable_bit) begin
        rx_buffer <= rx_word;
        rx_full   <= 1'b1;
        if (rx_full && !(rd && PADDR == ssp_pkg::OFF_RXBUF)) begin
          overrun <= 1'b1;
        end
      end else if (rd && PADDR == ssp_pkg::OFF_RXBUF) begin
        rx_full <= 1'b0;
      end
      if (wr && PADDR == ssp_pkg::OFF_CTRL1 && PWDATA[ssp_pkg::OVR_BIT] &&
          !(done && rx_enable_bit && rx_full)) begin
        overrun <= 1'b0;
      end
    end
  end

  // Pending flags are write-one-to-clear; a new event in the clear cycle stays.
  assign sim_cond = spec.sim_mode && spec.tx_irq_source_bit && spec.error_signal_out_bit;

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sim_cond_prev <= 1'b0;
    end else begin
      sim_cond_prev <= sim_cond;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rx_pending_flag <= 1'b0;
    end else if (done && rx_enable_bit && !rx_full) begin
      rx_pending_flag <= 1'b1;
    end else if (wr && PADDR == ssp_pkg::OFF_PEND && PWDATA[ssp_pkg::PEND_RX_BIT]) begin
      rx_pending_flag <= 1'b0;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      tx_pending_flag <= 1'b0;
    end else if ((sim_cond && !sim_cond_prev) ||
                 (start && !spec.tx_irq_source_bit) ||
                 (done && spec.tx_irq_source_bit)) begin
      tx_pending_flag <= 1'b1;
    end else if (wr && PADDR == ssp_pkg::OFF_PEND && PWDATA[ssp_pkg::PEND_TX_BIT]) begin
      tx_pending_flag <= 1'b0;
    end
  end

  // Flow request: low only when an externally clocked word can be taken.
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_FLOW_REQUEST_OUT <= 1'b1;
    end else if (ctrl0.internal_clk || !ctrl0.flow_enable) begin
      O_FLOW_REQUEST_OUT <= 1'b1;
    end else if (start || state == ssp_pkg::ST_SHIFT) begin
      O_FLOW_REQUEST_OUT <= 1'b1;
    end else begin
      O_FLOW_REQUEST_OUT <= !(rx_enable_bit && !rx_full);
    end
  end

  // Forced cutoff releases the request and clock pins, and the data pin if remapped, two core clock edges after the input goes low, whatever the shifter does.
  assign cut                    = ctrl0.cutoff_enable_bit && !cutoff_in_n;
  assign O_FLOW_REQUEST_OUT_OE  = !cut;
  assign O_SHIFT_CLK_PIN        = int_clk;
  assign O_SHIFT_CLK_PIN_OE     = ctrl0.internal_clk && !cut;
  assign O_SERIAL_OUT_PIN_OE    = !(cut && ctrl0.pin_remap_bit);

  // Simple channel: a short burst of the default level on switch-over, then
  // the pin is released to high impedance.
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      pf_prev <= 1'b0;
    end else begin
      pf_prev <= spec.pin_function_bit;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      dflt_cnt <= '0;
    end else if (spec.pin_function_bit && !pf_prev && !spec.output_disable_bit &&
                 spec.internal_clock_bit) begin
      dflt_cnt <= ssp_pkg::DEFAULT_LVL_CYC;
    end else if (dflt_cnt != '0) begin
      dflt_cnt <= dflt_cnt - 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_SIMPLE_SERIAL_OUT <= 1'b0;
    end else begin
      O_SIMPLE_SERIAL_OUT <= spec.default_level_bit;
    end
  end

  assign O_SIMPLE_SERIAL_OUT_OE = (dflt_cnt != '0);

endmodule

// >>> ssp_pkg.sv
// Behaviour
// - External clock with flow control: request pin goes low when reception is possible.
// - Request pin goes high as soon as a reception begins.
// - Internal shift clock: the flow-control request has no effect on the pin.
// - Start only with transmit enabled, buffer holding data, clear-to-send low if used.
// - Edge select 0: launch on fall, sample on rise; 1 swaps; idle level checked.
// - Reception runs the transmitter; dummy data is shifted out while receiving.
// - Internal clock: enable plus buffer write makes the device generate the clock.
// - External clock: shifting proceeds only on edges the peer supplies.
// - New word while receive buffer is full flags overrun; buffer content undefined.
// - Overrun leaves the receive pending flag unchanged.
// - External clock rests at idle level before receive, transmit enable and data.
// - Cutoff enabled and cutoff input low: tri-state request, clock, remapped data pin.
// - SIM mode: setting source and error-output bits raises a transmit pending flag.
// - Simple channel: port-to-serial switch briefly drives the default level.
package ssp_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int WORD_W = 8;

  localparam logic [ADDR_W-1:0] OFF_CTRL0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_TXBUF = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RXBUF = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_PEND  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_SPEC  = 8'h14;

  typedef struct packed {
    logic pin_remap_bit;
    logic cutoff_enable_bit;
    logic cts_enable;
    logic flow_enable;
    logic internal_clk;
    logic clock_edge_select;
  } ssp_ctrl0_t;

  localparam int CTRL0_W = 6;
  localparam logic [CTRL0_W-1:0] CTRL0_RST = 6'h00;

  typedef struct packed {
    logic internal_clock_bit;
    logic output_disable_bit;
    logic default_level_bit;
    logic pin_function_bit;
    logic condition_out_select;
    logic error_signal_out_bit;
    logic tx_irq_source_bit;
    logic sim_mode;
  } ssp_spec_t;

  localparam int SPEC_W = 8;
  localparam logic [SPEC_W-1:0] SPEC_RST = 8'h00;

  localparam int TXEN_BIT    = 0;
  localparam int RXEN_BIT    = 1;
  localparam int TXEMPTY_BIT = 2;
  localparam int RXFULL_BIT  = 3;
  localparam int OVR_BIT     = 4;
  localparam int PEND_RX_BIT = 0;
  localparam int PEND_TX_BIT = 1;

  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] LAST_BIT   = 4'h7;
  localparam logic [CNT_W-1:0] HALF_DIV   = 4'h4;
  localparam logic [WORD_W-1:0] TXBUF_RST = 8'hff;

  localparam int CLK_PERIOD_NS   = 4;
  localparam int DEFAULT_LVL_NS  = 10;
  localparam int DEFAULT_LVL_RAW = DEFAULT_LVL_NS / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] DEFAULT_LVL_CYC =
    CNT_W'((DEFAULT_LVL_RAW < 1) ? 1 : DEFAULT_LVL_RAW);

  typedef enum logic {
    ST_IDLE,
    ST_SHIFT
  } ssp_state_t;

endpackage

// >>> ssp_sync2.sv
`timescale 1ns/1ps
module ssp_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta <= '0;
      o_q  <= '0;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end

endmodule

// >>> ssp_top_assertions.sv
`timescale 1ns/1ps
module ssp_top_chk (
  input wire logic                       I_CORE_CLK,
  input wire logic                       I_NRST,
  input wire logic                       PSEL,
  input wire logic                       PENABLE,
  input wire logic                       PWRITE,
  input wire logic [ssp_pkg::ADDR_W-1:0] PADDR,
  input wire logic [ssp_pkg::DATA_W-1:0] PRDATA,
  input wire logic                       PSLVERR,
  input wire logic                       I_FORCED_CUTOFF_IN_N,
  input wire logic                       O_SHIFT_CLK_PIN,
  input wire logic                       O_SHIFT_CLK_PIN_OE,
  input wire logic                       O_SERIAL_OUT_PIN_OE,
  input wire logic                       O_FLOW_REQUEST_OUT,
  input wire logic                       O_FLOW_REQUEST_OUT_OE,
  input wire logic                       O_SIMPLE_SERIAL_OUT_OE
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);

  sequence s_clk_hold;
    $stable(O_SHIFT_CLK_PIN) [*3];
  endsequence

  sequence s_pulse_two;
    O_SIMPLE_SERIAL_OUT_OE ##1 !O_SIMPLE_SERIAL_OUT_OE;
  endsequence

  a_cutoff_flow_oe: assert property (I_FORCED_CUTOFF_IN_N [*6] |-> O_FLOW_REQUEST_OUT_OE)
    else $error("flow request released while cutoff input inactive");
  a_cutoff_group: assert property (!O_SERIAL_OUT_PIN_OE |-> !O_FLOW_REQUEST_OUT_OE && !O_SHIFT_CLK_PIN_OE)
    else $error("data pin floated without request and clock pins");
  a_internal_no_flow: assert property (O_SHIFT_CLK_PIN_OE [*3] |-> O_FLOW_REQUEST_OUT)
    else $error("flow request active with internal shift clock");
  a_clk_half_period: assert property (O_SHIFT_CLK_PIN_OE && $changed(O_SHIFT_CLK_PIN) |=> s_clk_hold)
    else $error("internal shift clock half period too short");
  a_default_pulse: assert property ($rose(O_SIMPLE_SERIAL_OUT_OE) |=> s_pulse_two)
    else $error("default level pulse not two cycles");
  a_unmapped_err: assert property (PSEL && PENABLE && PADDR[1:0] == 2'b00 |-> PSLVERR == (PADDR > 8'h14))
    else $error("slave error does not match address map");
  a_unmapped_zero: assert property (PSEL && PENABLE && !PWRITE && PADDR > 8'h14 |-> PRDATA == 32'h0)
    else $error("unmapped read returned nonzero data");
  a_read_hold: assert property (PSEL && PENABLE |=> $stable(PRDATA))
    else $error("read data moved right after access");
endmodule

bind ssp_top ssp_top_chk u_chk (
  .I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
  .I_FORCED_CUTOFF_IN_N(I_FORCED_CUTOFF_IN_N), .O_SHIFT_CLK_PIN(O_SHIFT_CLK_PIN),
  .O_SHIFT_CLK_PIN_OE(O_SHIFT_CLK_PIN_OE), .O_SERIAL_OUT_PIN_OE(O_SERIAL_OUT_PIN_OE),
  .O_FLOW_REQUEST_OUT(O_FLOW_REQUEST_OUT), .O_FLOW_REQUEST_OUT_OE(O_FLOW_REQUEST_OUT_OE),
  .O_SIMPLE_SERIAL_OUT_OE(O_SIMPLE_SERIAL_OUT_OE)
);

// >>> ssp_peer.sv
`timescale 1ns/1ps
module ssp_peer (
  input  wire logic       i_pol,
  input  wire logic       i_dut_clk,
  input  wire logic       i_dut_clk_oe,
  input  wire logic       i_dut_out,
  input  wire logic [7:0] i_word,
  output logic            o_clk,
  output logic            o_data,
  output logic [7:0]      o_got
);
  logic tog = 1'b0;
  int   idx = 0;

  initial o_data = 1'b0;

  // Between words the link clock rests at the idle level of the polarity.
  assign o_clk = i_dut_clk_oe ? i_dut_clk : (tog ^ ~i_pol);

  task burst();
    repeat (16) #40 tog = ~tog;
  endtask

  // Arriving at the idle level is always a capture edge, so a mode switch
  // can only shift in junk and never misaligns the bit count.
  always @(o_clk) begin
    if ((o_clk ^ i_pol) == 1'b0) begin
      o_data = i_word[idx[2:0]];
      idx = idx + 1;
    end else begin
      o_got = {i_dut_out, o_got[7:1]};
      if (idx == 8) begin
        idx = 0;
        o_data = ~o_data;
      end
    end
  end
endmodule

// >>> sync_serial_port_bench.sv
`timescale 1ns/1ps
module sync_serial_port_bench;
  logic        clk, nrst, psel, pen, pwr, cts, cut_n, pol, err, ready, slverr;
  logic        sck, sin, sclk, sclk_oe, sout, sout_oe, flow, flow_oe, simp, simp_oe;
  logic [7:0]  paddr, word, got, w;
  logic [31:0] pwdata, prdata, rd, seed;
  int          num_errors, check_count, cyc, k;

  ssp_top dut (
    .I_CORE_CLK(clk), .I_NRST(nrst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(ready), .PSLVERR(slverr),
    .I_SHIFT_CLK_PIN(sck), .O_SHIFT_CLK_PIN(sclk), .O_SHIFT_CLK_PIN_OE(sclk_oe),
    .I_SERIAL_IN(sin), .O_SERIAL_OUT_PIN(sout), .O_SERIAL_OUT_PIN_OE(sout_oe),
    .O_FLOW_REQUEST_OUT(flow), .O_FLOW_REQUEST_OUT_OE(flow_oe),
    .I_CLEAR_TO_SEND_IN(cts), .I_FORCED_CUTOFF_IN_N(cut_n),
    .O_SIMPLE_SERIAL_OUT(simp), .O_SIMPLE_SERIAL_OUT_OE(simp_oe)
  );

  ssp_peer peer (
    .i_pol(pol), .i_dut_clk(sclk), .i_dut_clk_oe(sclk_oe), .i_dut_out(sout),
    .i_word(word), .o_clk(sck), .o_data(sin), .o_got(got)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function logic [31:0] ctrl1_exp(input logic full, input logic ovr);
    return {27'h0, ovr, full, 3'h7};
  endfunction

  task conclude();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    check_count++;
    if (got_v !== exp_v) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (ready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = slverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // Polls the status word until the given bit is up; the overrun case waits on
  // its own bit because the full bit is already set by the word before it.
  task wait_full(input int b);
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[b] !== 1'b1 && n < 100) begin
      apb(1'b0, 8'h04, 32'h0);
      n++;
    end
  endtask

  task xfer(input logic ext, input int b);
    void'(xs());
    w = seed[7:0];
    word = seed[15:8];
    apb(1'b1, 8'h04, 32'h3);
    if (ext) begin
      repeat (20) if (flow !== 1'b0) @(posedge clk);
      chk({31'h0, flow}, 32'h0);
    end
    apb(1'b1, 8'h08, {24'h0, w});
    repeat (3) @(posedge clk);
    if (ext) begin
      chk({31'h0, flow}, 32'h1);
      peer.burst();
    end
    wait_full(b);
    chk({24'h0, got}, {24'h0, w});
  endtask

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    {psel, pen, pwr, paddr, pwdata, cts, pol, word} = '0;
    {cut_n, nrst} = 2'b10;
    {num_errors, check_count, cyc} = '0;
    seed = 32'hb34c2596;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h4);
    apb(1'b0, 8'h18, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("reset and map test done");
    for (k = 0; k < 4; k++) begin
      pol = k[0];
      apb(1'b1, 8'h00, {29'h0, 1'b1, ~k[1], k[0]});
      xfer(k[1], 3);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, ctrl1_exp(1'b1, 1'b0));
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, {24'h0, word});
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, ctrl1_exp(1'b0, 1'b0));
      if (!k[1]) chk({31'h0, flow}, 32'h1);
      apb(1'b1, 8'h10, 32'h3);
      $display("transfer test %0d done", k);
    end
    pol = 1'b0;
    apb(1'b1, 8'h00, 32'h6);
    xfer(1'b0, 3);
    apb(1'b1, 8'h10, 32'h3);
    xfer(1'b0, 4);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, ctrl1_exp(1'b1, 1'b1));
    apb(1'b0, 8'h10, 32'h0);
    chk(rd & 32'h1, 32'h0);
    apb(1'b1, 8'h04, 32'h13);
    apb(1'b0, 8'h0c, 32'h0);
    $display("overrun test done");
    apb(1'b1, 8'h00, 32'h0a);
    cts <= 1'b1;
    apb(1'b1, 8'h08, xs());
    repeat (40) @(posedge clk);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h4, 32'h0);
    cts <= 1'b0;
    wait_full(3);
    chk(rd & 32'h4, 32'h4);
    apb(1'b0, 8'h0c, 32'h0);
    apb(1'b1, 8'h10, 32'h3);
    $display("clear to send test done");
    apb(1'b1, 8'h00, 32'h32);
    cut_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk({29'h0, flow_oe, sclk_oe, sout_oe}, 32'h0);
    cut_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk({31'h0, flow_oe}, 32'h1);
    $display("cutoff test done");
    apb(1'b1, 8'h14, 32'ha0);
    apb(1'b1, 8'h14, 32'hb0);
    repeat (5) if (simp_oe !== 1'b1) @(posedge clk);
    chk({30'h0, simp_oe, simp}, 32'h3);
    apb(1'b1, 8'h14, 32'h07);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd & 32'h2, 32'h2);
    $display("special mode test done");
    conclude();
  end
endmodule
